/* File: pcss_config_store.v */
// Pin setup register, working settings and boot loader of the converter controller.
// Assumes a decoded management command port and a synchronous reset that acts as power cycle.
// How it works
// RULE1: Pin setup bit 0 clear: bus on/off; set: secondary input with pull.
// RULE2: Secondary input active low gets pull-up, active high gets pull-down.
// RULE3: Bit 2 enables output-ok pin; 0x04 push-pull standalone, 0x00 disabled.
// RULE4: Droop-share codes carry mode bits 10 and bit 1 set, e.g. 0x82.
// RULE5: 0x24 is standalone high-Z output-ok; bit 5 high-Z, bit 1 clear.
// RULE6: 0xA7 is droop-share, high-Z output-ok, secondary input with pull.
// RULE7: Bits 4 and 3 are unsupported, always read 0, writes ignored.
// RULE8: Host writes the pin setup over the bus; it replaces shipped value.
// RULE9: Standalone parts default the pin setup to 0x04.
// RULE10: Droop-share parts default the pin setup to 0x86.
// RULE11: Two stored sets exist: factory default and user.
// RULE12: A valid user set is used ahead of the factory set.
// RULE13: The user area is empty when shipped.
// RULE14: At boot an empty user area loads the factory set into RAM.
// RULE15: Store-user command copies working settings into the user area.
// RULE16: Next power cycle loads the saved user set and runs from it.
// RULE17: Store-default command is refused; factory set stays intact.
// RULE18: Output-ok drive selects push-pull or high-Z when active.
// RULE19: Output-ok is active low by default; polarity set over the bus.
// RULE20: Missing marker or bad check makes the user area count as empty.
`timescale 1ns/10ps
`include "pcss_map.vh"

module pcss_config_store (
  input wire clk_in,
  input wire reset_in,
  input wire droop_variant_in,
  input wire nv_erase_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [7:0] cmd_code_in,
  input wire [7:0] cmd_wdata_in,
  output wire cmd_ready_out,
  output reg cmd_done_out,
  output reg cmd_reject_out,
  output reg [7:0] cmd_rdata_out,
  input wire power_ok_in,
  input wire secondary_remote_control_level_in,
  output wire output_ok_signal_out,
  output wire output_ok_signal_oe_out,
  output wire secondary_remote_control_pull_up_out,
  output wire secondary_remote_control_pull_down_out,
  output wire converter_on_out,
  output wire user_set_active_out,
  output wire nv_busy_out
);

  localparam [3:0] ST_BOOT = 4'b0001;
  localparam [3:0] ST_LOAD = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_SAVE = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg variant_q;
  reg user_active_q;
  reg [7:0] multi_function_pin_setup_q;
  reg [7:0] polarity_q;
  reg [7:0] operation_q;
  reg save_start_q;

  wire nv_busy;
  wire user_valid;
  wire [7:0] user_pin;
  wire [7:0] user_pol;
  wire [7:0] dflt_pin;
  wire [7:0] dflt_pol;

  wire take = cmd_valid_in && (state_q == ST_RUN);
  wire is_pin = (cmd_code_in == `PCSS_CMD_MULTI_PIN_SETUP);
  wire is_pol = (cmd_code_in == `PCSS_CMD_OUTPUT_POLARITY);
  wire is_op = (cmd_code_in == `PCSS_CMD_OPERATION);
  wire is_store_user = (cmd_code_in == `PCSS_CMD_STORE_USER_ALL) && cmd_write_in;
  wire known = is_pin || is_pol || is_op || is_store_user;

  // Unsupported bits dropped, bit 1 follows the droop-share mode
  function [7:0] pin_clean;
    input [7:0] v;
    reg [7:0] m;
    begin
      m = v & `PCSS_PIN_WRITE_MASK; // RULE7
      m[`PCSS_PIN_RESERVED_BIT] =
        (v[`PCSS_PIN_MODE_HI:`PCSS_PIN_MODE_LO] == `PCSS_MODE_DROOP_SHARE); // RULE4 RULE5 RULE6
      pin_clean = m;
    end
  endfunction

  assign cmd_ready_out = (state_q == ST_RUN);
  assign user_set_active_out = user_active_q;
  assign nv_busy_out = nv_busy;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: state_d = ST_LOAD;
      ST_LOAD: state_d = ST_RUN;
      ST_RUN: if (take && is_store_user) begin
        state_d = ST_SAVE;
      end
      ST_SAVE: if (!save_start_q && !nv_busy) begin
        state_d = ST_RUN;
      end
      default: state_d = ST_BOOT;
    endcase
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= ST_BOOT;
      variant_q <= 1'b0;
      user_active_q <= 1'b0;
      multi_function_pin_setup_q <= `PCSS_DFLT_PIN_STANDALONE;
      polarity_q <= `PCSS_DFLT_POLARITY;
      operation_q <= `PCSS_OP_RESET;
      save_start_q <= 1'b0;
      cmd_done_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      cmd_rdata_out <= 8'h00;
    end else begin
      state_q <= state_d;
      cmd_done_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      save_start_q <= 1'b0;
      if (state_q == ST_BOOT) begin
        variant_q <= droop_variant_in;
      end
      if (state_q == ST_LOAD) begin
        if (user_valid) begin
          multi_function_pin_setup_q <= pin_clean(user_pin); // RULE12 RULE16
          polarity_q <= user_pol;
          user_active_q <= 1'b1;
        end else begin
          multi_function_pin_setup_q <= dflt_pin; // RULE14 RULE9 RULE10
          polarity_q <= dflt_pol;
          user_active_q <= 1'b0;
        end
      end
      if (take) begin
        if (!known) begin
          cmd_reject_out <= 1'b1; // RULE17
        end else if (is_store_user) begin
          save_start_q <= 1'b1; // RULE15
          cmd_done_out <= 1'b1;
        end else if (cmd_write_in) begin
          cmd_done_out <= 1'b1;
          if (is_pin) begin
            multi_function_pin_setup_q <= pin_clean(cmd_wdata_in); // RULE8
          end
          if (is_pol) begin
            polarity_q <= cmd_wdata_in; // RULE19
          end
          if (is_op) begin
            operation_q <= cmd_wdata_in;
          end
        end else begin
          cmd_done_out <= 1'b1;
          cmd_rdata_out <= is_pin ? multi_function_pin_setup_q :
                           is_pol ? polarity_q : operation_q;
        end
      end
    end
  end

  pcss_nv_store u_nv (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .erase_in(nv_erase_in),
    .droop_variant_in(variant_q),
    .write_start_in(save_start_q),
    .pin_wdata_in(multi_function_pin_setup_q),
    .pol_wdata_in(polarity_q),
    .busy_out(nv_busy),
    .user_valid_out(user_valid),
    .user_pin_out(user_pin),
    .user_pol_out(user_pol),
    .dflt_pin_out(dflt_pin),
    .dflt_pol_out(dflt_pol)
  );

  pcss_pin_drive u_drive (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_setup_in(multi_function_pin_setup_q),
    .polarity_in(polarity_q),
    .operation_in(operation_q),
    .power_ok_in(power_ok_in),
    .secondary_remote_control_level_in(secondary_remote_control_level_in),
    .output_ok_signal_out(output_ok_signal_out),
    .output_ok_signal_oe_out(output_ok_signal_oe_out),
    .secondary_remote_control_pull_up_out(secondary_remote_control_pull_up_out),
    .secondary_remote_control_pull_down_out(secondary_remote_control_pull_down_out),
    .converter_on_out(converter_on_out)
  );

endmodule

/* File: pcss_map.vh */
// Constants of the pin setup and settings store block.
// Assumes inclusion by bare name from the design files only.
`ifndef PCSS_MAP_VH
`define PCSS_MAP_VH

// Command codes on the management command port
`define PCSS_CMD_OPERATION 8'h01
`define PCSS_CMD_STORE_DEFAULT_ALL 8'h11
`define PCSS_CMD_STORE_USER_ALL 8'h15
`define PCSS_CMD_OUTPUT_POLARITY 8'hE1
`define PCSS_CMD_MULTI_PIN_SETUP 8'hF9

// Fields of multi_function_pin_setup
`define PCSS_PIN_SECONDARY_REMOTE_CONTROL_BIT 0
`define PCSS_PIN_RESERVED_BIT 1
`define PCSS_PIN_OK_ENABLE_BIT 2
`define PCSS_PIN_EXT_REF_BIT 3
`define PCSS_PIN_TRACK_BIT 4
`define PCSS_PIN_OK_HIZ_BIT 5
`define PCSS_PIN_MODE_HI 7
`define PCSS_PIN_MODE_LO 6
`define PCSS_MODE_STANDALONE 2'b00
`define PCSS_MODE_DROOP_SHARE 2'b10
// Bits 4 and 3 never stored
`define PCSS_PIN_WRITE_MASK 8'hE7

// Fields of the output polarity byte
`define PCSS_POL_OK_HIGH_BIT 0
`define PCSS_POL_SECONDARY_REMOTE_CONTROL_HIGH_BIT 1

// Operation byte: bit 7 turns the converter on
`define PCSS_OP_ON_BIT 7
`define PCSS_OP_RESET 8'h00

// Factory defaults
`define PCSS_DFLT_PIN_STANDALONE 8'h04
`define PCSS_DFLT_PIN_DROOP 8'h86
`define PCSS_DFLT_POLARITY 8'h00

// User record layout in flash
`define PCSS_REC_MARKER 0
`define PCSS_REC_PIN 1
`define PCSS_REC_POL 2
`define PCSS_REC_CHECK 3
`define PCSS_REC_WORDS 4
`define PCSS_MARKER_VALUE 8'hA5

// Flash programming time
`define PCSS_NV_WRITE_NS 64
`define PCSS_CLK_NS 8
// 64 ns at an 8 ns clock, sized for the 8-bit busy counter
`define PCSS_NV_WRITE_CYCLES 8'h08

`endif

/* File: pcss_nv_store.v */
// Nonvolatile settings: fixed factory set and a user record with marker and check.
// Assumes the user array survives reset_in; erase_in models the empty shipped state.
`timescale 1ns/10ps
`include "pcss_map.vh"

module pcss_nv_store (
  input wire clk_in,
  input wire reset_in,
  input wire erase_in,
  input wire droop_variant_in,
  input wire write_start_in,
  input wire [7:0] pin_wdata_in,
  input wire [7:0] pol_wdata_in,
  output wire busy_out,
  output wire user_valid_out,
  output wire [7:0] user_pin_out,
  output wire [7:0] user_pol_out,
  output wire [7:0] dflt_pin_out,
  output wire [7:0] dflt_pol_out
);

  reg [7:0] user_mem_q [0:`PCSS_REC_WORDS-1];
  reg [7:0] busy_cnt_q;

  function [7:0] rec_check;
    input [7:0] a;
    input [7:0] b;
    begin
      rec_check = ~(a + b + `PCSS_MARKER_VALUE);
    end
  endfunction

  // Factory set is constant logic: nothing can overwrite it
  assign dflt_pin_out = droop_variant_in ? `PCSS_DFLT_PIN_DROOP : `PCSS_DFLT_PIN_STANDALONE; // RULE11
  assign dflt_pol_out = `PCSS_DFLT_POLARITY;
  assign user_pin_out = user_mem_q[`PCSS_REC_PIN];
  assign user_pol_out = user_mem_q[`PCSS_REC_POL];
  // Missing marker or bad check means empty
  assign user_valid_out = (user_mem_q[`PCSS_REC_MARKER] == `PCSS_MARKER_VALUE) &&
    (user_mem_q[`PCSS_REC_CHECK] == rec_check(user_pin_out, user_pol_out)); // RULE20
  assign busy_out = (busy_cnt_q != 8'h00);

  always @(posedge clk_in) begin
    if (reset_in) begin
      busy_cnt_q <= 8'h00;
    end else if (write_start_in && !busy_out) begin
      busy_cnt_q <= `PCSS_NV_WRITE_CYCLES;
    end else if (busy_out) begin
      busy_cnt_q <= busy_cnt_q - 8'h01;
    end
  end

  // Marker written last so a cut-short save reads as empty
  always @(posedge clk_in) begin
    if (erase_in) begin
      user_mem_q[`PCSS_REC_MARKER] <= 8'h00; // RULE13
      user_mem_q[`PCSS_REC_PIN] <= 8'h00;
      user_mem_q[`PCSS_REC_POL] <= 8'h00;
      user_mem_q[`PCSS_REC_CHECK] <= 8'h00;
    end else if (write_start_in && !busy_out) begin
      user_mem_q[`PCSS_REC_MARKER] <= 8'h00;
      user_mem_q[`PCSS_REC_PIN] <= pin_wdata_in; // RULE15
      user_mem_q[`PCSS_REC_POL] <= pol_wdata_in;
      user_mem_q[`PCSS_REC_CHECK] <= rec_check(pin_wdata_in, pol_wdata_in);
    end else if (busy_cnt_q == 8'h01) begin
      user_mem_q[`PCSS_REC_MARKER] <= `PCSS_MARKER_VALUE;
    end
  end

endmodule

/* File: pcss_pin_drive.v */
// Drives the output-ok pin, the secondary on/off pulls and the converter enable.
// Assumes power_ok_in and the secondary control level are synchronous to clk_in.
`timescale 1ns/10ps
`include "pcss_map.vh"

module pcss_pin_drive (
  input wire clk_in,
  input wire reset_in,
  input wire [7:0] pin_setup_in,
  input wire [7:0] polarity_in,
  input wire [7:0] operation_in,
  input wire power_ok_in,
  input wire secondary_remote_control_level_in,
  output reg output_ok_signal_out,
  output reg output_ok_signal_oe_out,
  output reg secondary_remote_control_pull_up_out,
  output reg secondary_remote_control_pull_down_out,
  output reg converter_on_out
);

  wire ok_en = pin_setup_in[`PCSS_PIN_OK_ENABLE_BIT];
  wire ok_hiz = pin_setup_in[`PCSS_PIN_OK_HIZ_BIT];
  wire ok_high = polarity_in[`PCSS_POL_OK_HIGH_BIT];
  wire sec_sel = pin_setup_in[`PCSS_PIN_SECONDARY_REMOTE_CONTROL_BIT];
  wire sec_high = polarity_in[`PCSS_POL_SECONDARY_REMOTE_CONTROL_HIGH_BIT];
  wire ok_level = power_ok_in ? ok_high : ~ok_high; // RULE19

  always @(posedge clk_in) begin
    if (reset_in) begin
      output_ok_signal_out <= 1'b0;
      output_ok_signal_oe_out <= 1'b0;
      secondary_remote_control_pull_up_out <= 1'b0;
      secondary_remote_control_pull_down_out <= 1'b0;
      converter_on_out <= 1'b0;
    end else begin
      output_ok_signal_out <= ok_level;
      // Released while active so parallel pins can be wired together
      output_ok_signal_oe_out <= ok_en && !(ok_hiz && power_ok_in); // RULE3 RULE5 RULE18
      secondary_remote_control_pull_up_out <= sec_sel && !sec_high; // RULE2
      secondary_remote_control_pull_down_out <= sec_sel && sec_high; // RULE2
      converter_on_out <= sec_sel ? (secondary_remote_control_level_in == sec_high)
                                  : operation_in[`PCSS_OP_ON_BIT]; // RULE1
    end
  end

endmodule

/* File: pcss_checker.sv */
// Checker of the pin setup store command port, pulls and flash timing.
// Assumes binding to pcss_config_store; one clock, synchronous reset_in.
`timescale 1ns/10ps
module pcss_checker (
  input wire clk_in,
  input wire reset_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [7:0] cmd_code_in,
  input wire cmd_ready_out,
  input wire cmd_done_out,
  input wire cmd_reject_out,
  input wire [7:0] cmd_rdata_out,
  input wire secondary_remote_control_pull_up_out,
  input wire secondary_remote_control_pull_down_out,
  input wire nv_busy_out
);
  wire take = cmd_valid_in && cmd_ready_out;
  wire pin_rd = take && !cmd_write_in && cmd_code_in == 8'hF9;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_one_answer: assert property (take |=> cmd_done_out != cmd_reject_out)
    else $error("request without single answer");
  chk_default_refused: assert property (take && cmd_write_in && cmd_code_in == 8'h11 |=>
    cmd_reject_out && !cmd_done_out) else $error("store default not refused");
  chk_unused_zero: assert property (pin_rd |=> cmd_rdata_out[4:3] == 2'b00)
    else $error("unsupported pin bits set");
  chk_reserved_mode: assert property (pin_rd |=>
    cmd_rdata_out[1] == (cmd_rdata_out[7:6] == 2'b10)) else $error("bit 1 not tied to mode");
  chk_pulls_apart: assert property (!(secondary_remote_control_pull_up_out && secondary_remote_control_pull_down_out))
    else $error("both pulls on");
  chk_save_stall: assert property (take && cmd_write_in && cmd_code_in == 8'h15 |=>
    cmd_done_out && !cmd_ready_out ##1 !cmd_ready_out) else $error("save did not stall");
  chk_save_length: assert property ($rose(nv_busy_out) |-> nv_busy_out[*8] ##1 !nv_busy_out)
    else $error("flash write length wrong");
  chk_boot_ready: assert property ($fell(reset_in) |->
    !cmd_ready_out ##1 !cmd_ready_out ##1 cmd_ready_out) else $error("boot load timing wrong");
  chk_busy_closed: assert property (nv_busy_out |-> !cmd_ready_out)
    else $error("request open while writing");
  cover property (take && cmd_write_in && cmd_code_in == 8'h15);
  cover property (cmd_reject_out);
  cover property (secondary_remote_control_pull_down_out);
endmodule
bind pcss_config_store pcss_checker chk_u (.clk_in(clk_in), .reset_in(reset_in),
  .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in),
  .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
  .cmd_reject_out(cmd_reject_out), .cmd_rdata_out(cmd_rdata_out),
  .secondary_remote_control_pull_up_out(secondary_remote_control_pull_up_out), .secondary_remote_control_pull_down_out(secondary_remote_control_pull_down_out),
  .nv_busy_out(nv_busy_out));

/* File: pcss_host_model.sv */
// Host side of the management command port, one request at a time.
// Assumes requests start at a falling edge; ready may drop during a save.
`timescale 1ns/10ps
module pcss_host_model (
  input wire clk_in,
  input wire cmd_ready_in,
  input wire cmd_done_in,
  input wire cmd_reject_in,
  input wire [7:0] cmd_rdata_in,
  output logic cmd_valid_out = 1'b0,
  output logic cmd_write_out = 1'b0,
  output logic [7:0] cmd_code_out = 8'h5A,
  output logic [7:0] cmd_wdata_out = 8'hA5
);
  task xfer(input w, input [7:0] c, input [7:0] d, output [7:0] r, output [1:0] a);
    integer n;
    begin
      n = 0;
      a = 2'b00;
      r = 8'h00;
      @(negedge clk_in);
      while (!cmd_ready_in && n < 40) begin
        n = n + 1;
        @(negedge clk_in);
      end
      if (n < 40) begin
        cmd_valid_out = 1'b1;
        cmd_write_out = w;
        cmd_code_out = c;
        cmd_wdata_out = d;
        @(negedge clk_in);
        a = {cmd_done_in, cmd_reject_in};
        r = cmd_rdata_in;
        cmd_valid_out = 1'b0;
        // Released lines flip so stale values never look valid
        cmd_code_out = ~c;
        cmd_wdata_out = ~d;
      end
    end
  endtask
endmodule

/* File: pcss_config_store_test.sv */
// Self-checking bench of the pin setup and settings store.
// Assumes the host model drives commands; other inputs change at the falling edge.
`timescale 1ns/10ps
module pcss_config_store_test;
  typedef struct packed {logic w; logic [7:0] c; logic [7:0] d;
    logic [1:0] a; logic [7:0] r;} pcss_row_t;
  typedef struct packed {logic [7:0] p; logic [7:0] q; logic l; logic [3:0] e;} pcss_pin_t;
  logic clk_in = 0, reset_in = 1, droop = 0, erase = 0, pok = 1, sec_lvl = 1;
  wire cv, cw, rdy, dn, rj, oo, ooe, pu, pd, on, ua, nb;
  wire [7:0] cc, cd, rd;
  logic [7:0] got;
  logic [1:0] ans;
  integer mismatches = 0, n_checks = 0, i;
  pcss_row_t rows[17] = '{'{0, 8'hF9, 8'h00, 2'b10, 8'h04}, '{1, 8'hF9, 8'h24, 2'b10, 8'h00},
    '{0, 8'hF9, 8'h00, 2'b10, 8'h24}, '{1, 8'hF9, 8'hA7, 2'b10, 8'h00},
    '{0, 8'hF9, 8'h00, 2'b10, 8'hA7}, '{1, 8'hF9, 8'hFF, 2'b10, 8'h00},
    '{0, 8'hF9, 8'h00, 2'b10, 8'hE5}, '{1, 8'hF9, 8'h80, 2'b10, 8'h00},
    '{0, 8'hF9, 8'h00, 2'b10, 8'h82}, '{1, 8'hF9, 8'h00, 2'b10, 8'h00},
    '{0, 8'hF9, 8'h00, 2'b10, 8'h00}, '{1, 8'h11, 8'h00, 2'b01, 8'h00},
    '{0, 8'h15, 8'h00, 2'b01, 8'h00}, '{1, 8'h33, 8'h00, 2'b01, 8'h00},
    '{1, 8'hE1, 8'h01, 2'b10, 8'h00}, '{0, 8'hE1, 8'h00, 2'b10, 8'h01},
    '{1, 8'h01, 8'h80, 2'b10, 8'h00}};
  // Expected {oe, pull up, pull down, on}; operation byte stays on
  pcss_pin_t pins[5] = '{'{8'h04, 8'h00, 1, 4'b1001}, '{8'h24, 8'h00, 1, 4'b0001},
    '{8'h01, 8'h00, 1, 4'b0100}, '{8'h01, 8'h02, 1, 4'b0011}, '{8'h00, 8'h00, 1, 4'b0001}};
  initial forever #4 clk_in = ~clk_in;
  pcss_config_store dut_u (.clk_in(clk_in), .reset_in(reset_in), .droop_variant_in(droop),
    .nv_erase_in(erase), .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_code_in(cc),
    .cmd_wdata_in(cd), .cmd_ready_out(rdy), .cmd_done_out(dn), .cmd_reject_out(rj),
    .cmd_rdata_out(rd), .power_ok_in(pok), .secondary_remote_control_level_in(sec_lvl),
    .output_ok_signal_out(oo), .output_ok_signal_oe_out(ooe), .secondary_remote_control_pull_up_out(pu),
    .secondary_remote_control_pull_down_out(pd), .converter_on_out(on), .user_set_active_out(ua),
    .nv_busy_out(nb));
  pcss_host_model host_u (.clk_in(clk_in), .cmd_ready_in(rdy), .cmd_done_in(dn),
    .cmd_reject_in(rj), .cmd_rdata_in(rd), .cmd_valid_out(cv), .cmd_write_out(cw),
    .cmd_code_out(cc), .cmd_wdata_out(cd));
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input [7:0] g, input [7:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cmd(input w, input [7:0] c, input [7:0] d);
    host_u.xfer(w, c, d, got, ans);
    if (ans === 2'b00) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t no answer", $time);
      print_verdict;
    end
  endtask
  task power_cycle(input e);
    reset_in = 1;
    erase = e;
    repeat (8) @(negedge clk_in);
    erase = 0;
    reset_in = 0;
    repeat (3) @(negedge clk_in);
  endtask
  initial begin
    power_cycle(1);
    check({7'h00, ua}, 8'h00);
    for (i = 0; i < 17; i = i + 1) begin
      cmd(rows[i].w, rows[i].c, rows[i].d);
      check({6'h00, ans}, {6'h00, rows[i].a});
      if (!rows[i].w && ans === 2'b10) check(got, rows[i].r);
    end
    $display("test command table done");
    for (i = 0; i < 5; i = i + 1) begin
      sec_lvl = pins[i].l;
      cmd(1, 8'hF9, pins[i].p);
      cmd(1, 8'hE1, pins[i].q);
      repeat (3) @(negedge clk_in);
      check({4'h0, ooe, pu, pd, on}, {4'h0, pins[i].e});
      if (pins[i].e[3]) check({7'h00, oo}, 8'h00);
    end
    // High-Z drive must still pull low while not ok, active-high level
    cmd(1, 8'hF9, 8'h24);
    cmd(1, 8'hE1, 8'h01);
    pok = 0;
    repeat (3) @(negedge clk_in);
    check({6'h00, ooe, oo}, 8'h02);
    pok = 1;
    repeat (3) @(negedge clk_in);
    check({6'h00, ooe, oo}, 8'h01);
    $display("test pin drive done");
    cmd(1, 8'hF9, 8'hA7);
    cmd(1, 8'h15, 8'h00);
    check({6'h00, ans}, 8'h02);
    i = 0;
    while ((nb || !rdy) && i < 40) begin
      i = i + 1;
      @(negedge clk_in);
    end
    if (i == 40) check(8'h01, 8'h00);
    power_cycle(0);
    check({7'h00, ua}, 8'h01);
    cmd(0, 8'hF9, 8'h00);
    check(got, 8'hA7);
    cmd(0, 8'hE1, 8'h00);
    check(got, 8'h01);
    $display("test user save done");
    droop = 1;
    power_cycle(1);
    check({7'h00, ua}, 8'h00);
    cmd(0, 8'hF9, 8'h00);
    check(got, 8'h86);
    $display("test droop default done");
    print_verdict;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    $display("[ERR] %0t run limit reached", $time);
    print_verdict;
  end
endmodule
